/* src/dpio_map.svh */
// Constants for the dual parallel I/O adapter: register selects, control bits, reset values.
// Assumes inclusion by bare name from every design file that needs a constant.
//
// Function
// RULE1: Two identical sides, each with output, direction and control registers.
// RULE2: Control bit two picks direction register at zero, output register at one.
// RULE3: Each direction bit set to one makes its line an output.
// RULE4: Output register writes store data and drive lines that are outputs.
// RULE5: Side B reads return pins for inputs and stored bits for outputs.
// RULE6: Side A reads return the pin level on every bit.
// RULE7: Control bits seven and six are flags, readable, untouched by writes.
// RULE8: Reading the output register or reset clears both flags of that side.
// RULE9: Control bit one picks rising or falling edge that sets flag one.
// RULE10: Control bit zero gates flag one onto the active-low interrupt output.
// RULE11: Enabling bit zero later asserts the interrupt for a pending flag.
// RULE12: With bit five low, line two is an input governed by bits four, three.
// RULE13: Interrupt output asserts when either enabled flag is set.
// RULE14: With bit five high, line two is an output and flag two reads zero.
// RULE15: With bits five and four high, line two follows bit three.
// RULE16: Side A handshake goes low after output read, high when flag one sets.
// RULE17: Side B handshake goes low after output write, high on active input edge.
// RULE18: Side A pulse goes low on output read, high at next bus-enable fall.
// RULE19: Side B pulse goes low after output write, high at next bus-enable rise.
// RULE20: No strobe for side A writes or side B reads.
// RULE21: Reset clears all registers: lines inputs, interrupts off, direction selected.
`ifndef DPIO_MAP_SVH
`define DPIO_MAP_SVH
`define DPIO_RS_A_DATA 2'h0
`define DPIO_RS_A_CTRL 2'h1
`define DPIO_RS_B_DATA 2'h2
`define DPIO_RS_B_CTRL 2'h3
`define DPIO_BIT_IEN1 0
`define DPIO_BIT_EDGE1 1
`define DPIO_BIT_SEL 2
`define DPIO_BIT_C3 3
`define DPIO_BIT_C4 4
`define DPIO_BIT_OUT2 5
`define DPIO_BIT_FLAG2 6
`define DPIO_BIT_FLAG1 7
`define DPIO_CTRL_WMASK 8'h3F
`define DPIO_BYTE_RESET 8'h00
`endif

/* src/dpio_pkg.sv */
// Types shared by the adapter files.
// Assumes nothing beyond a SystemVerilog compiler.
package dpio_pkg;
    typedef logic [7:0] dpio_byte_t;
endpackage

/* src/dpio_side.sv */
// One side of the adapter: registers, flags, line-two logic and interrupt.
// Assumes bus inputs synchronous to clk; e_rise and e_fall are one-cycle pulses.
`timescale 1ns/1ns
`default_nettype none
`include "dpio_map.svh"
module dpio_side #(
    parameter bit SIDE_B = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Host access, one-cycle strobes
    input wire logic wr_data,
    input wire logic wr_ctrl,
    input wire logic rd_data,
    input wire logic e_rise,
    input wire logic e_fall,
    input wire dpio_pkg::dpio_byte_t wdata,
    // Read views
    output dpio_pkg::dpio_byte_t data_view,
    output dpio_pkg::dpio_byte_t ctrl_view,
    // Peripheral lines
    input wire dpio_pkg::dpio_byte_t pin_in,
    output dpio_pkg::dpio_byte_t pin_out,
    output dpio_pkg::dpio_byte_t pin_oe,
    input wire logic ctl_input,
    input wire logic ctl_two_in,
    output logic ctl_two_out,
    output logic ctl_two_oe,
    output logic int_out_n
);
    dpio_pkg::dpio_byte_t out_reg, out_next, dir_reg, dir_next;
    logic [5:0] ctl_reg, ctl_next;
    logic flag_one_reg, flag_one_next, flag_two_reg, flag_two_next;
    logic c1_prev_reg, c2_prev_reg, line_reg, line_next, arm_reg, arm_next;
    logic edge1, edge2, sel_out;

    assign sel_out = ctl_reg[`DPIO_BIT_SEL]; // RULE2
    assign edge1 = ctl_reg[`DPIO_BIT_EDGE1] ? (ctl_input & ~c1_prev_reg)
                                            : (~ctl_input & c1_prev_reg); // RULE9
    assign edge2 = ctl_reg[`DPIO_BIT_C4] ? (ctl_two_in & ~c2_prev_reg)
                                         : (~ctl_two_in & c2_prev_reg); // RULE12

    always_comb begin
        out_next = out_reg;
        dir_next = dir_reg;
        ctl_next = ctl_reg;
        flag_one_next = flag_one_reg;
        flag_two_next = flag_two_reg;
        line_next = line_reg;
        arm_next = arm_reg;
        if (wr_data && sel_out) begin
            out_next = wdata; // RULE4
        end
        if (wr_data && !sel_out) begin
            dir_next = wdata; // RULE1
        end
        if (wr_ctrl) begin
            ctl_next = wdata[5:0]; // RULE7
        end
        // A set in the same cycle as the clearing read wins.
        if (rd_data && sel_out) begin
            flag_one_next = 1'b0; // RULE8
            flag_two_next = 1'b0; // RULE8
        end
        if (edge1) begin
            flag_one_next = 1'b1; // RULE9
        end
        if (edge2 && !ctl_reg[`DPIO_BIT_OUT2]) begin
            flag_two_next = 1'b1; // RULE12
        end
        if (ctl_next[`DPIO_BIT_OUT2]) begin
            flag_two_next = 1'b0; // RULE14
        end
        if (ctl_reg[`DPIO_BIT_OUT2] && ctl_reg[`DPIO_BIT_C4]) begin
            line_next = ctl_reg[`DPIO_BIT_C3]; // RULE15
            arm_next = 1'b0;
        end else if (ctl_reg[`DPIO_BIT_OUT2]) begin
            if (!SIDE_B) begin
                // Side A strobes come from output reads only.
                if (arm_reg && e_fall) begin
                    line_next = 1'b1; // RULE18
                    arm_next = 1'b0;
                end
                if (ctl_reg[`DPIO_BIT_C3] && rd_data && sel_out) begin
                    line_next = 1'b0; // RULE18
                    arm_next = 1'b1;
                end
                if (!ctl_reg[`DPIO_BIT_C3]) begin
                    if (rd_data && sel_out) begin
                        arm_next = 1'b1;
                    end else if (arm_reg && e_fall) begin
                        line_next = 1'b0; // RULE16
                        arm_next = 1'b0;
                    end
                    if (edge1) begin
                        line_next = 1'b1; // RULE16
                    end
                end
            end else begin
                // Side B strobes come from output writes only.
                if (wr_data && sel_out) begin
                    arm_next = 1'b1; // RULE20
                end else if (arm_reg && e_rise) begin
                    line_next = 1'b0; // RULE17
                    arm_next = 1'b0;
                end else if (ctl_reg[`DPIO_BIT_C3] && !line_reg && e_rise) begin
                    line_next = 1'b1; // RULE19
                end
                if (!ctl_reg[`DPIO_BIT_C3] && edge1) begin
                    line_next = 1'b1; // RULE17
                end
            end
        end else begin
            line_next = 1'b1;
            arm_next = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_reg <= `DPIO_BYTE_RESET; // RULE21
            dir_reg <= `DPIO_BYTE_RESET; // RULE21
            ctl_reg <= 6'h00;
            flag_one_reg <= 1'b0;
            flag_two_reg <= 1'b0;
            c1_prev_reg <= 1'b0;
            c2_prev_reg <= 1'b0;
            line_reg <= 1'b1;
            arm_reg <= 1'b0;
        end else begin
            out_reg <= out_next;
            dir_reg <= dir_next;
            ctl_reg <= ctl_next;
            flag_one_reg <= flag_one_next;
            flag_two_reg <= flag_two_next;
            c1_prev_reg <= ctl_input;
            c2_prev_reg <= ctl_two_in;
            line_reg <= line_next;
            arm_reg <= arm_next;
        end
    end

    assign pin_out = out_reg; // RULE4
    assign pin_oe = dir_reg; // RULE3
    assign ctl_two_out = line_reg;
    assign ctl_two_oe = ctl_reg[`DPIO_BIT_OUT2]; // RULE14
    assign int_out_n = ~((flag_one_reg & ctl_reg[`DPIO_BIT_IEN1]) |
                         (flag_two_reg & ctl_reg[`DPIO_BIT_C3] &
                          ~ctl_reg[`DPIO_BIT_OUT2])); // RULE10 RULE11 RULE13
    assign ctrl_view = {flag_one_reg, flag_two_reg, ctl_reg};
    always_comb begin
        if (!sel_out) begin
            data_view = dir_reg;
        end else if (SIDE_B) begin
            data_view = (dir_reg & out_reg) | (~dir_reg & pin_in); // RULE5
        end else begin
            data_view = pin_in; // RULE6
        end
    end

    // A side pulse mode: an output read must pull line two low on the next cycle.
    sequence s_pulse_read;
        !SIDE_B && ctl_reg[`DPIO_BIT_OUT2] && !ctl_reg[`DPIO_BIT_C4] &&
            ctl_reg[`DPIO_BIT_C3] && rd_data && sel_out;
    endsequence
    sequence s_line_low;
        !line_reg;
    endsequence

    a_flag_read_clear: assert property (@(posedge clk) disable iff (sys_rst) // RULE8
        (rd_data && sel_out && !edge1) |=> !flag_one_reg)
        else $error("flag one survived an output read");
    a_flag_edge_set: assert property (@(posedge clk) disable iff (sys_rst) // RULE9
        edge1 |=> flag_one_reg)
        else $error("flag one missed an edge");
    a_int_follow: assert property (@(posedge clk) disable iff (sys_rst) // RULE10
        (flag_one_reg && ctl_reg[`DPIO_BIT_IEN1]) |-> !int_out_n)
        else $error("interrupt not asserted");
    a_flag_two_out: assert property (@(posedge clk) disable iff (sys_rst) // RULE14
        ctl_reg[`DPIO_BIT_OUT2] |-> !flag_two_reg)
        else $error("flag two set in output mode");
    a_ctrl_write_keep: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
        (wr_ctrl && !edge1 && !(rd_data && sel_out)) |=>
            flag_one_reg == $past(flag_one_reg))
        else $error("control write changed flag one");
    a_set_reset_line: assert property (@(posedge clk) disable iff (sys_rst) // RULE15
        (ctl_reg[`DPIO_BIT_OUT2] && ctl_reg[`DPIO_BIT_C4]) |=>
            line_reg == $past(ctl_reg[`DPIO_BIT_C3]))
        else $error("line two not following bit three");
    a_out_write: assert property (@(posedge clk) disable iff (sys_rst) // RULE4
        (wr_data && sel_out) |=> pin_out == $past(wdata))
        else $error("output write lost");
    a_dir_write: assert property (@(posedge clk) disable iff (sys_rst) // RULE3
        (wr_data && !sel_out) |=> pin_oe == $past(wdata))
        else $error("direction write not applied");
    a_int_two: assert property (@(posedge clk) disable iff (sys_rst) // RULE13
        (flag_two_reg && ctl_reg[`DPIO_BIT_C3] && !ctl_reg[`DPIO_BIT_OUT2]) |-> !int_out_n)
        else $error("interrupt missed flag two");
    a_pulse_start: assert property (@(posedge clk) disable iff (sys_rst) // RULE18
        s_pulse_read |=> s_line_low)
        else $error("pulse not started by output read");
endmodule
`default_nettype wire

/* src/dpio_top.sv */
// Top of the dual parallel I/O adapter: register select decode and bus-enable edges.
// Assumes host strobes and pins synchronous to clk; pin drivers resolved outside.
`timescale 1ns/1ns
`default_nettype none
`include "dpio_map.svh"
module dpio_top (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Host bus
    input wire logic bus_e,
    input wire logic chip_sel,
    input wire logic rd_wr_n,
    input wire logic [1:0] reg_sel,
    input wire dpio_pkg::dpio_byte_t bus_wdata,
    output dpio_pkg::dpio_byte_t bus_rdata,
    // Side A pins
    input wire dpio_pkg::dpio_byte_t side_a_in,
    output dpio_pkg::dpio_byte_t side_a_out,
    output dpio_pkg::dpio_byte_t side_a_oe,
    input wire logic side_a_ctl_input,
    input wire logic side_a_ctl_line_two_in,
    output logic side_a_ctl_line_two_out,
    output logic side_a_ctl_line_two_oe,
    output logic side_a_int_out_n,
    // Side B pins
    input wire dpio_pkg::dpio_byte_t side_b_in,
    output dpio_pkg::dpio_byte_t side_b_out,
    output dpio_pkg::dpio_byte_t side_b_oe,
    input wire logic side_b_ctl_input,
    input wire logic side_b_ctl_line_two_in,
    output logic side_b_ctl_line_two_out,
    output logic side_b_ctl_line_two_oe,
    output logic side_b_int_out_n
);
    logic e_prev_reg, e_rise, e_fall, acc;
    dpio_pkg::dpio_byte_t a_data, a_ctrl, b_data, b_ctrl, rdata_reg, rdata_next;

    // An access is taken once, at the falling bus-enable edge.
    assign e_rise = bus_e & ~e_prev_reg;
    assign e_fall = ~bus_e & e_prev_reg;
    assign acc = e_fall & chip_sel;

    always_comb begin
        rdata_next = rdata_reg;
        if (bus_e && chip_sel && rd_wr_n) begin
            case (reg_sel)
                `DPIO_RS_A_DATA: rdata_next = a_data;
                `DPIO_RS_A_CTRL: rdata_next = a_ctrl;
                `DPIO_RS_B_DATA: rdata_next = b_data;
                default: rdata_next = b_ctrl;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            e_prev_reg <= 1'b0;
            rdata_reg <= `DPIO_BYTE_RESET;
        end else begin
            e_prev_reg <= bus_e;
            rdata_reg <= rdata_next;
        end
    end
    assign bus_rdata = rdata_reg;

    dpio_side #(.SIDE_B(1'b0)) u_side_a (
        .clk(clk), .sys_rst(sys_rst),
        .wr_data(acc && !rd_wr_n && reg_sel == `DPIO_RS_A_DATA),
        .wr_ctrl(acc && !rd_wr_n && reg_sel == `DPIO_RS_A_CTRL),
        .rd_data(acc && rd_wr_n && reg_sel == `DPIO_RS_A_DATA),
        .e_rise(e_rise), .e_fall(e_fall), .wdata(bus_wdata),
        .data_view(a_data), .ctrl_view(a_ctrl),
        .pin_in(side_a_in), .pin_out(side_a_out), .pin_oe(side_a_oe),
        .ctl_input(side_a_ctl_input), .ctl_two_in(side_a_ctl_line_two_in),
        .ctl_two_out(side_a_ctl_line_two_out), .ctl_two_oe(side_a_ctl_line_two_oe),
        .int_out_n(side_a_int_out_n)
    );

    dpio_side #(.SIDE_B(1'b1)) u_side_b (
        .clk(clk), .sys_rst(sys_rst),
        .wr_data(acc && !rd_wr_n && reg_sel == `DPIO_RS_B_DATA),
        .wr_ctrl(acc && !rd_wr_n && reg_sel == `DPIO_RS_B_CTRL),
        .rd_data(acc && rd_wr_n && reg_sel == `DPIO_RS_B_DATA),
        .e_rise(e_rise), .e_fall(e_fall), .wdata(bus_wdata),
        .data_view(b_data), .ctrl_view(b_ctrl),
        .pin_in(side_b_in), .pin_out(side_b_out), .pin_oe(side_b_oe),
        .ctl_input(side_b_ctl_input), .ctl_two_in(side_b_ctl_line_two_in),
        .ctl_two_out(side_b_ctl_line_two_out), .ctl_two_oe(side_b_ctl_line_two_oe),
        .int_out_n(side_b_int_out_n)
    );
endmodule
`default_nettype wire

/* tb/dpio_peer.sv */
// Peripheral-side model of one adapter side: resolves data and line-two pin levels.
// Assumes the bench commands the peripheral's own drive levels and loading.
`timescale 1ns/1ns
`default_nettype none
module dpio_peer (
    // Adapter drive
    input wire dpio_pkg::dpio_byte_t out,
    input wire dpio_pkg::dpio_byte_t oe,
    input wire logic two_out,
    input wire logic two_oe,
    // Peripheral drive commanded by the bench
    input wire dpio_pkg::dpio_byte_t ext,
    input wire dpio_pkg::dpio_byte_t low_mask,
    input wire logic two_ext,
    // Resolved pin levels
    output dpio_pkg::dpio_byte_t pin,
    output logic two_pin
);
    // The low mask models heavy loading that drags a driven line low, so reads can tell
    // a pin level from a stored register bit.
    assign pin = ((out & oe) | (ext & ~oe)) & ~low_mask;
    assign two_pin = two_oe ? two_out : two_ext;
endmodule
`default_nettype wire

/* tb/test_dual_parallel_io_adapter.sv */
// Self-checking bench for the dual parallel I/O adapter.
// Assumes dpio_top and the peripheral model dpio_peer are compiled first.
`timescale 1ns/1ns
`default_nettype none
module test_dual_parallel_io_adapter;
    typedef struct {logic [2:0] sel; dpio_pkg::dpio_byte_t exp;} dpio_note_s;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic bus_e = 1'b0, chip_sel = 1'b0, rd_wr_n = 1'b1;
    logic [1:0] reg_sel = 2'h0;
    dpio_pkg::dpio_byte_t wd = 8'h00, low_a = 8'h00, rdata, a_out, a_oe, b_out, b_oe;
    dpio_pkg::dpio_byte_t a_pin, b_pin, d, o, e, c, seen;
    dpio_pkg::dpio_byte_t ext [2] = '{8'h00, 8'h00};
    logic ctl [2] = '{1'b1, 1'b1};
    logic two_ext [2] = '{1'b1, 1'b1};
    logic a_two_o, a_two_oe, b_two_o, b_two_oe, a_two_pin, b_two_pin, a_int_n, b_int_n;
    integer seed = 59118, bad_count = 0, checks = 0;
    dpio_note_s q [$];
    dpio_note_s n;
    string view_name [7] = '{"rdata", "lines", "a_out", "a_oe", "b_out", "b_oe", "two_oe"};
    event res_ev;
    always #2 clk = ~clk;
    dpio_top dut_u (.clk(clk), .sys_rst(sys_rst), .bus_e(bus_e), .chip_sel(chip_sel),
        .rd_wr_n(rd_wr_n), .reg_sel(reg_sel), .bus_wdata(wd), .bus_rdata(rdata),
        .side_a_in(a_pin), .side_a_out(a_out), .side_a_oe(a_oe), .side_a_ctl_input(ctl[0]),
        .side_a_ctl_line_two_in(a_two_pin), .side_a_ctl_line_two_out(a_two_o),
        .side_a_ctl_line_two_oe(a_two_oe), .side_a_int_out_n(a_int_n),
        .side_b_in(b_pin), .side_b_out(b_out), .side_b_oe(b_oe), .side_b_ctl_input(ctl[1]),
        .side_b_ctl_line_two_in(b_two_pin), .side_b_ctl_line_two_out(b_two_o),
        .side_b_ctl_line_two_oe(b_two_oe), .side_b_int_out_n(b_int_n));
    dpio_peer peer_a (.out(a_out), .oe(a_oe), .two_out(a_two_o), .two_oe(a_two_oe),
        .ext(ext[0]), .low_mask(low_a), .two_ext(two_ext[0]), .pin(a_pin), .two_pin(a_two_pin));
    dpio_peer peer_b (.out(b_out), .oe(b_oe), .two_out(b_two_o), .two_oe(b_two_oe),
        .ext(ext[1]), .low_mask(low_a), .two_ext(two_ext[1]), .pin(b_pin), .two_pin(b_two_pin));
    task automatic chk(input logic [2:0] what, input dpio_pkg::dpio_byte_t sn, ex);
        checks = checks + 1;
        if (sn !== ex) begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED %s expected %h seen %h", view_name[what], ex, sn);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // One host access: the side effect lands at the edge that sees the enable fall.
    task automatic acc(input logic rd, input logic [1:0] rs, input dpio_pkg::dpio_byte_t dt);
        bus_e <= 1'b1;
        chip_sel <= 1'b1;
        rd_wr_n <= rd;
        reg_sel <= rs;
        wd <= dt;
        @(posedge clk);
        bus_e <= 1'b0;
        @(posedge clk);
        chip_sel <= 1'b0;
        @(posedge clk);
    endtask
    task automatic note(input logic [2:0] s, input dpio_pkg::dpio_byte_t ex);
        #1;
        q.push_back('{s, ex});
        ->res_ev;
        @(posedge clk);
    endtask
    always @(res_ev) begin
        n = q.pop_front();
        case (n.sel)
            3'h0: seen = rdata;
            3'h1: seen = {4'h0, a_two_o, b_two_o, a_int_n, b_int_n};
            3'h2: seen = a_out;
            3'h3: seen = a_oe;
            3'h4: seen = b_out;
            3'h5: seen = b_oe;
            default: seen = {6'h00, a_two_oe, b_two_oe};
        endcase
        chk(n.sel, seen, n.exp);
    end
    initial begin
        repeat (5000) @(posedge clk);
        bad_count = bad_count + 1;
        complete_run();
    end
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        note(3'h1, 8'h0F);
        for (int v = 2; v < 7; v++) begin
            note(3'(v), 8'h00);
        end
        acc(1'b1, 2'h1, 8'h00);
        note(3'h0, 8'h00);
        for (int s = 0; s < 2; s++) begin
            d = 8'($random(seed)) | 8'h01;
            o = 8'($random(seed)) | 8'h01;
            e = 8'($random(seed));
            acc(1'b0, 2'(2 * s), d);
            acc(1'b1, 2'(2 * s), 8'h00);
            note(3'h0, d);
            acc(1'b0, 2'(2 * s + 1), 8'h04);
            acc(1'b0, 2'(2 * s), o);
            note(3'(2 + 2 * s), o);
            note(3'(3 + 2 * s), d);
            ext[s] <= e;
            low_a <= 8'h01;
            acc(1'b1, 2'(2 * s), 8'h00);
            note(3'h0, ((o & d) | (e & ~d)) & ~((s == 0) ? 8'h01 : 8'h00));
        end
        low_a <= 8'h00;
        for (int s = 0; s < 2; s++) begin
            for (int k = 0; k < 2; k++) begin
                c = 8'h0D | 8'(k * 8'h12);
                ctl[s] <= !k;
                two_ext[s] <= !k;
                acc(1'b0, 2'(2 * s + 1), c);
                acc(1'b1, 2'(2 * s), 8'h00);
                ctl[s] <= k;
                two_ext[s] <= k;
                repeat (2) @(posedge clk);
                note(3'h1, (s == 0) ? 8'h0D : 8'h0E);
                acc(1'b1, 2'(2 * s + 1), 8'h00);
                note(3'h0, 8'hC0 | c);
                acc(1'b1, 2'(2 * s), 8'h00);
                note(3'h1, 8'h0F);
            end
        end
        acc(1'b0, 2'h1, 8'h06);
        ctl[0] <= 1'b0;
        repeat (2) @(posedge clk);
        ctl[0] <= 1'b1;
        repeat (2) @(posedge clk);
        note(3'h1, 8'h0F);
        acc(1'b0, 2'h1, 8'hC7);
        note(3'h1, 8'h0D);
        acc(1'b1, 2'h1, 8'h00);
        note(3'h0, 8'h87);
        acc(1'b1, 2'h0, 8'h00);
        for (int s = 0; s < 2; s++) begin
            acc(1'b0, 2'(2 * s + 1), 8'h3C);
            note(3'h1, 8'h0F);
            note(3'h6, (s == 0) ? 8'h02 : 8'h01);
            acc(1'b0, 2'(2 * s + 1), 8'h34);
            note(3'h1, (s == 0) ? 8'h07 : 8'h0B);
            two_ext[s] <= ~two_ext[s];
            acc(1'b1, 2'(2 * s + 1), 8'h00);
            note(3'h0, 8'h34);
            acc(1'b0, 2'(2 * s + 1), 8'h04);
        end
        acc(1'b0, 2'h1, 8'h24);
        acc(1'b1, 2'h0, 8'h00);
        acc(1'b1, 2'h1, 8'h00);
        note(3'h1, 8'h07);
        ctl[0] <= 1'b0;
        repeat (2) @(posedge clk);
        note(3'h1, 8'h0F);
        acc(1'b0, 2'h1, 8'h2C);
        acc(1'b1, 2'h0, 8'h00);
        note(3'h1, 8'h07);
        acc(1'b1, 2'h1, 8'h00);
        note(3'h1, 8'h0F);
        acc(1'b0, 2'h0, 8'h55);
        note(3'h1, 8'h0F);
        acc(1'b1, 2'h1, 8'h00);
        acc(1'b0, 2'h3, 8'h24);
        acc(1'b0, 2'h2, 8'hA5);
        note(3'h4, 8'hA5);
        note(3'h1, 8'h0F);
        acc(1'b1, 2'h3, 8'h00);
        note(3'h1, 8'h0B);
        ctl[1] <= 1'b0;
        repeat (2) @(posedge clk);
        note(3'h1, 8'h0F);
        acc(1'b0, 2'h3, 8'h2C);
        acc(1'b1, 2'h2, 8'h00);
        acc(1'b1, 2'h3, 8'h00);
        note(3'h1, 8'h0F);
        acc(1'b0, 2'h2, 8'h5A);
        acc(1'b1, 2'h3, 8'h00);
        note(3'h1, 8'h0B);
        acc(1'b1, 2'h3, 8'h00);
        note(3'h1, 8'h0F);
        complete_run();
    end
endmodule
`default_nettype wire
